// [rtl/ccrs_consts.svh]
`ifndef CCRS_CONSTS_SVH
`define CCRS_CONSTS_SVH
`define CCRS_ADDR_EDGE_POS_LO 8'h2C
`define CCRS_ADDR_EDGE_POS_MID 8'h2D
`define CCRS_ADDR_EDGE_POS_HI 8'h2E
`define CCRS_ADDR_DELAY_SEL 8'h29
`define CCRS_ADDR_FS_LO 8'h30
`define CCRS_ADDR_FS_HI 8'h31
`define CCRS_ADDR_PWR1 8'h37
`define CCRS_ADDR_PWR2 8'h38
`define CCRS_ADDR_PWR3 8'h39
`define CCRS_ADDR_PWR4 8'h3A
`define CCRS_ADDR_TS_CTRL 8'h3B
`define CCRS_ADDR_REFO_CTRL 8'h3C
`define CCRS_ADDR_FBDIV1 8'h3D
`define CCRS_RST_FS 16'hA000
`define CCRS_RST_PWR 8'h4B
`define CCRS_PWR_LOW 8'h46
`define CCRS_PWR_HIGH 8'h4B
`define CCRS_RST_TS 8'h00
`define CCRS_RST_REFO 8'h01
`define CCRS_RST_FBDIV1 8'h00
`define CCRS_RST_DELAY_SEL 4'h0
`define CCRS_RST_EDGE_POS 24'h000000
`define CCRS_BIT_TS_RECV 0
`define CCRS_BIT_TS_TERM 1
`define CCRS_BIT_REFO_EN 0
`endif

// [rtl/ccrs_pkg.sv]
package ccrs_pkg;
	typedef enum logic [1:0] {
		CCRS_MODE_HIGH_PERF = 2'h0,
		CCRS_MODE_LOW_POWER = 2'h1,
		CCRS_MODE_RESERVED = 2'h3
	} ccrs_mode_t;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ccrs_req_t;
endpackage

// [rtl/ccrs_pos_store.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ccrs_consts.svh"
// Captured edge position; never written from the register port
module ccrs_pos_store (
	input wire logic core_clk_in,
	input wire logic resetn_in,
	input wire logic capture_in,
	input wire logic [23:0] pos_in,
	output logic [23:0] pos_out
);
	logic [23:0] pos_ff;
	logic [23:0] nxt_pos;
	always_comb begin
		nxt_pos = capture_in ? pos_in : pos_ff;
	end
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			pos_ff <= `CCRS_RST_EDGE_POS;
		end else begin
			pos_ff <= nxt_pos;
		end
	end
	assign pos_out = pos_ff;
endmodule
`default_nettype wire

// [rtl/ccrs_regs.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ccrs_consts.svh"
// Behaviour
// - 24-bit read-only edge position, resets zero
// - 16-bit full-scale code, reset A000, single output
// - Power code resets 4B; 46 low power
// - Timestamp bit 0 enables receiver, reset 0
// - Reference output driven when enabled and PLL on
// - Reference output enable resets to one
// - 4-bit delay select, resets zero
module ccrs_regs (
	input wire logic core_clk_in,
	input wire logic resetn_in,
	input wire ccrs_pkg::ccrs_req_t req_in,
	output logic [7:0] rdata_out,
	input wire logic pos_capture_in,
	input wire logic [23:0] pos_value_in,
	input wire logic pll_enable_in,
	input wire logic cal_enable_in,
	input wire logic serial_link_enable_in,
	output logic [15:0] full_scale_code_out,
	output logic [3:0] alignment_delay_select_out,
	output ccrs_pkg::ccrs_mode_t power_mode_out,
	output logic power_codes_mismatch_out,
	output logic mode_write_unsafe_out,
	output logic timestamp_receiver_enable_out,
	output logic timestamp_termination_mode_out,
	output logic reference_clock_output_enable_out,
	output logic [7:0] synth_feedback_divider_one_out
);
	logic [15:0] fs_ff, nxt_fs;
	logic [7:0] pwr_ff [4];
	logic [7:0] nxt_pwr [4];
	logic [7:0] ts_ff, nxt_ts;
	logic [7:0] refo_ff, nxt_refo;
	logic [7:0] fbdiv_ff, nxt_fbdiv;
	logic [3:0] dsel_ff, nxt_dsel;
	logic [7:0] rdata_ff, nxt_rdata;
	logic unsafe_ff, nxt_unsafe;
	logic [23:0] pos;

	function automatic ccrs_pkg::ccrs_mode_t decode_mode(input logic [7:0] code);
		if (code == `CCRS_PWR_LOW) begin
			return ccrs_pkg::CCRS_MODE_LOW_POWER;
		end else if (code == `CCRS_PWR_HIGH) begin
			return ccrs_pkg::CCRS_MODE_HIGH_PERF;
		end
		return ccrs_pkg::CCRS_MODE_RESERVED;
	endfunction

	function automatic logic is_wr(input ccrs_pkg::ccrs_req_t r, input logic [7:0] a);
		return r.wr && (r.addr == a);
	endfunction

	ccrs_pos_store u_pos (
		.core_clk_in(core_clk_in),
		.resetn_in(resetn_in),
		.capture_in(pos_capture_in),
		.pos_in(pos_value_in),
		.pos_out(pos)
	);

	always_comb begin
		nxt_fs = fs_ff;
		nxt_ts = ts_ff;
		nxt_refo = refo_ff;
		nxt_fbdiv = fbdiv_ff;
		nxt_dsel = dsel_ff;
		if (is_wr(req_in, `CCRS_ADDR_FS_LO)) begin
			nxt_fs[7:0] = req_in.wdata;
		end
		if (is_wr(req_in, `CCRS_ADDR_FS_HI)) begin
			nxt_fs[15:8] = req_in.wdata;
		end
		if (is_wr(req_in, `CCRS_ADDR_TS_CTRL)) begin
			nxt_ts = req_in.wdata;
		end
		if (is_wr(req_in, `CCRS_ADDR_REFO_CTRL)) begin
			nxt_refo = req_in.wdata;
		end
		if (is_wr(req_in, `CCRS_ADDR_FBDIV1)) begin
			nxt_fbdiv = req_in.wdata;
		end
		if (is_wr(req_in, `CCRS_ADDR_DELAY_SEL)) begin
			nxt_dsel = req_in.wdata[3:0];
		end
	end

	// Power code write while calibration or link is live is still stored, but flagged
	always_comb begin
		nxt_unsafe = unsafe_ff;
		for (int i = 0; i < 4; i++) begin
			nxt_pwr[i] = pwr_ff[i];
			if (is_wr(req_in, 8'(`CCRS_ADDR_PWR1 + i))) begin
				nxt_pwr[i] = req_in.wdata;
				if (cal_enable_in || serial_link_enable_in) begin
					nxt_unsafe = 1'b1;
				end
			end
		end
	end

	// Reads are a mux registered into rdata_ff; the position word has no read side effect
	always_comb begin
		case (req_in.addr)
			`CCRS_ADDR_EDGE_POS_LO: nxt_rdata = pos[7:0];
			`CCRS_ADDR_EDGE_POS_MID: nxt_rdata = pos[15:8];
			`CCRS_ADDR_EDGE_POS_HI: nxt_rdata = pos[23:16];
			`CCRS_ADDR_DELAY_SEL: nxt_rdata = {4'h0, dsel_ff};
			`CCRS_ADDR_FS_LO: nxt_rdata = fs_ff[7:0];
			`CCRS_ADDR_FS_HI: nxt_rdata = fs_ff[15:8];
			`CCRS_ADDR_PWR1: nxt_rdata = pwr_ff[0];
			`CCRS_ADDR_PWR2: nxt_rdata = pwr_ff[1];
			`CCRS_ADDR_PWR3: nxt_rdata = pwr_ff[2];
			`CCRS_ADDR_PWR4: nxt_rdata = pwr_ff[3];
			`CCRS_ADDR_TS_CTRL: nxt_rdata = ts_ff;
			`CCRS_ADDR_REFO_CTRL: nxt_rdata = refo_ff;
			`CCRS_ADDR_FBDIV1: nxt_rdata = fbdiv_ff;
			default: nxt_rdata = 8'h00;
		endcase
		if (!req_in.rd) begin
			nxt_rdata = rdata_ff;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			fs_ff <= `CCRS_RST_FS;
			ts_ff <= `CCRS_RST_TS;
			refo_ff <= `CCRS_RST_REFO;
			fbdiv_ff <= `CCRS_RST_FBDIV1;
			dsel_ff <= `CCRS_RST_DELAY_SEL;
			rdata_ff <= 8'h00;
			unsafe_ff <= 1'b0;
			for (int i = 0; i < 4; i++) begin
				pwr_ff[i] <= `CCRS_RST_PWR;
			end
		end else begin
			fs_ff <= nxt_fs;
			ts_ff <= nxt_ts;
			refo_ff <= nxt_refo;
			fbdiv_ff <= nxt_fbdiv;
			dsel_ff <= nxt_dsel;
			rdata_ff <= nxt_rdata;
			unsafe_ff <= nxt_unsafe;
			for (int i = 0; i < 4; i++) begin
				pwr_ff[i] <= nxt_pwr[i];
			end
		end
	end

	assign rdata_out = rdata_ff;
	assign full_scale_code_out = fs_ff;
	assign alignment_delay_select_out = dsel_ff;
	assign power_mode_out = decode_mode(pwr_ff[0]);
	// Exposes a partial four-code update so the analog side can hold its mode
	assign power_codes_mismatch_out = (pwr_ff[1] != pwr_ff[0]) || (pwr_ff[2] != pwr_ff[0]) ||
		(pwr_ff[3] != pwr_ff[0]);
	assign mode_write_unsafe_out = unsafe_ff;
	assign timestamp_receiver_enable_out = ts_ff[`CCRS_BIT_TS_RECV];
	assign timestamp_termination_mode_out = ts_ff[`CCRS_BIT_TS_TERM];
	assign reference_clock_output_enable_out = refo_ff[`CCRS_BIT_REFO_EN] && pll_enable_in;
	assign synth_feedback_divider_one_out = fbdiv_ff;

	chk_fs_reset_value: assert property (@(posedge core_clk_in)
		!resetn_in |=> fs_ff == 16'hA000) else $error("full-scale reset value wrong");
	chk_pwr_reset_high: assert property (@(posedge core_clk_in)
		!resetn_in |=> power_mode_out == ccrs_pkg::CCRS_MODE_HIGH_PERF) else $error("power mode reset wrong");
	chk_pwr_low_decode: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
		is_wr(req_in, 8'h37) && req_in.wdata == 8'h46 |=> power_mode_out == ccrs_pkg::CCRS_MODE_LOW_POWER)
		else $error("low power code not decoded");
	chk_ts_enable_bit: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
		is_wr(req_in, 8'h3B) |=> timestamp_receiver_enable_out == $past(req_in.wdata[0]))
		else $error("timestamp enable does not follow bit 0");
	chk_ts_reset_off: assert property (@(posedge core_clk_in)
		!resetn_in |=> !timestamp_receiver_enable_out) else $error("timestamp receiver on after reset");
	chk_refo_gating: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
		is_wr(req_in, 8'h3C) |=> reference_clock_output_enable_out == ($past(req_in.wdata[0]) && pll_enable_in))
		else $error("reference gating wrong");
	chk_refo_reset_on: assert property (@(posedge core_clk_in)
		!resetn_in ##1 pll_enable_in |-> reference_clock_output_enable_out) else $error("reference not on by default");
	chk_dsel_width: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
		is_wr(req_in, 8'h29) |=> alignment_delay_select_out == $past(req_in.wdata[3:0]))
		else $error("delay select not stored");
	chk_pos_write_ignored: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
		is_wr(req_in, 8'h2C) && !pos_capture_in |=> $stable(pos)) else $error("position changed by write");
	chk_pos_read_back: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
		req_in.rd && req_in.addr == 8'h2E |=> rdata_out == $past(pos[23:16])) else $error("position read wrong");
	chk_pos_capture_load: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
		pos_capture_in |=> pos == $past(pos_value_in)) else $error("position capture not loaded");
	chk_pos_reset_zero: assert property (@(posedge core_clk_in)
		!resetn_in |=> pos == 24'h000000) else $error("position not zero after reset");
	chk_pos_read_lo: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
		req_in.rd && req_in.addr == 8'h2C |=> rdata_out == $past(pos[7:0]))
		else $error("position low byte read wrong");
	chk_fs_lo_write: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
		is_wr(req_in, 8'h30) |=> full_scale_code_out[7:0] == $past(req_in.wdata))
		else $error("full-scale low byte not stored");
	chk_fs_hi_write: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
		is_wr(req_in, 8'h31) |=> full_scale_code_out[15:8] == $past(req_in.wdata))
		else $error("full-scale high byte not stored");
	chk_pwr_high_decode: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
		is_wr(req_in, 8'h37) && req_in.wdata == 8'h4B |=> power_mode_out == ccrs_pkg::CCRS_MODE_HIGH_PERF)
		else $error("high performance code not decoded");
	chk_pwr_reserved: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
		is_wr(req_in, 8'h37) && req_in.wdata != 8'h46 && req_in.wdata != 8'h4B |=>
		power_mode_out == ccrs_pkg::CCRS_MODE_RESERVED) else $error("reserved code not flagged");
	chk_unsafe_set: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
		is_wr(req_in, 8'h37) && (cal_enable_in || serial_link_enable_in) |=> mode_write_unsafe_out)
		else $error("unsafe power write not flagged");
	chk_unsafe_sticky: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
		mode_write_unsafe_out |=> mode_write_unsafe_out) else $error("unsafe flag cleared without reset");
	cov_low_power: cover property (@(posedge core_clk_in) power_mode_out == ccrs_pkg::CCRS_MODE_LOW_POWER);
	cov_reserved_mode: cover property (@(posedge core_clk_in) power_mode_out == ccrs_pkg::CCRS_MODE_RESERVED);
	cov_unsafe_write: cover property (@(posedge core_clk_in) $rose(mode_write_unsafe_out));
	cov_pos_capture: cover property (@(posedge core_clk_in) pos_capture_in ##2 req_in.wr);
endmodule
`default_nettype wire

// [sim/ccrs_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Host side of the register port: one request per call, then the strobes drop
module ccrs_host_model (
	input wire logic core_clk_in,
	output ccrs_pkg::ccrs_req_t req_out
);
	initial req_out = '0;
	task automatic access(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk_in);
		req_out = '{wr: w, rd: r, addr: a, wdata: d};
		@(negedge core_clk_in);
		// Released address and data flip so a stale address can never pass for a held one
		req_out = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask
endmodule
`default_nettype wire

// [sim/converter_config_register_slice_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module converter_config_register_slice_tb;
	logic core_clk_in = 1'b0;
	logic resetn_in = 1'b0;
	ccrs_pkg::ccrs_req_t req;
	ccrs_pkg::ccrs_mode_t mode;
	logic [7:0] rdata, fb;
	logic cap = 1'b0, pll = 1'b1, cal = 1'b0, link = 1'b0;
	logic mism, unsafe, ts_rx, ts_term, refo, rd_pend = 1'b0;
	logic [23:0] pos = 24'h000000, p;
	logic [15:0] fs_out, f;
	logic [3:0] dsel;
	logic [7:0] exp_q[$];
	logic [15:0] tbl [14] = '{16'h2C00, 16'h2D00, 16'h2E00, 16'h2900, 16'h3000, 16'h31A0, 16'h374B,
		16'h384B, 16'h394B, 16'h3A4B, 16'h3B00, 16'h3C01, 16'h3D00, 16'h5000};
	int n_fail = 0;
	int n_tests = 0;
	always #12.5 core_clk_in = ~core_clk_in;
	ccrs_host_model i_host (.core_clk_in(core_clk_in), .req_out(req));
	ccrs_regs i_dut (.core_clk_in(core_clk_in), .resetn_in(resetn_in), .req_in(req), .rdata_out(rdata),
		.pos_capture_in(cap), .pos_value_in(pos), .pll_enable_in(pll), .cal_enable_in(cal),
		.serial_link_enable_in(link), .full_scale_code_out(fs_out), .alignment_delay_select_out(dsel),
		.power_mode_out(mode), .power_codes_mismatch_out(mism), .mode_write_unsafe_out(unsafe),
		.timestamp_receiver_enable_out(ts_rx), .timestamp_termination_mode_out(ts_term),
		.reference_clock_output_enable_out(refo), .synth_feedback_divider_one_out(fb));
	task automatic cmp(input logic [23:0] g, input logic [23:0] e);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
		if (r) exp_q.push_back(e);
		i_host.access(w, r, a, d);
	endtask
	// Read data lands one edge after the request, so it is judged at the next falling edge
	always @(posedge core_clk_in) rd_pend <= req.rd;
	always @(negedge core_clk_in) begin
		if (rd_pend && exp_q.size() > 0) cmp({16'h0000, rdata}, {16'h0000, exp_q.pop_front()});
		else if (rd_pend) cmp(24'h000001, 24'h000000);
	end
	initial begin
		repeat (4000) @(posedge core_clk_in);
		n_fail++;
		$display("CHECK FAILED at %0t: run did not finish", $time);
		report_and_stop();
	end
	initial begin
		void'($urandom(32'h7E18));
		repeat (4) @(negedge core_clk_in);
		resetn_in = 1'b1;
		foreach (tbl[i]) acc(1'b0, 1'b1, tbl[i][15:8], 8'h00, tbl[i][7:0]);
		cmp(24'({fs_out, mode, refo, ts_rx}), 24'({16'hA000, ccrs_pkg::CCRS_MODE_HIGH_PERF, 2'b10}));
		$display("test 1 done");
		p = 24'($urandom);
		pos = p;
		cap = 1'b1;
		@(negedge core_clk_in);
		cap = 1'b0;
		pos = ~p;
		acc(1'b1, 1'b0, 8'h2C, ~p[7:0], 8'h00);
		for (int k = 0; k < 6; k++) acc(1'b0, 1'b1, 8'(8'h2C + k % 3), 8'h00, p[8 * (k % 3) +: 8]);
		$display("test 2 done");
		f = 16'h2000 + 16'($urandom_range(16'hDFFF));
		acc(1'b1, 1'b1, 8'h30, f[7:0], 8'h00);
		acc(1'b1, 1'b0, 8'h31, f[15:8], 8'h00);
		cmp(24'(fs_out), 24'(f));
		// Delay select is picked from the position word read back above
		acc(1'b1, 1'b1, 8'h29, {4'h0, p[3:0]}, 8'h00);
		cmp(24'(dsel), 24'(p[3:0]));
		$display("test 3 done");
		for (int k = 0; k < 4; k++) acc(1'b1, 1'b0, 8'(8'h37 + k), 8'h46, 8'h00);
		cal = 1'b1;
		@(negedge core_clk_in);
		cal = 1'b0;
		cmp(24'({mode, mism, unsafe}), 24'({ccrs_pkg::CCRS_MODE_LOW_POWER, 2'b00}));
		acc(1'b1, 1'b1, 8'h37, 8'h00, 8'h46);
		cmp(24'({mode, mism}), 24'({ccrs_pkg::CCRS_MODE_RESERVED, 1'b1}));
		link = 1'b1;
		acc(1'b1, 1'b0, 8'h37, 8'h4B, 8'h00);
		link = 1'b0;
		cmp(24'({mode, unsafe}), 24'({ccrs_pkg::CCRS_MODE_HIGH_PERF, 1'b1}));
		// Mid-run reset clears the sticky flag so the calibration path can set it again
		resetn_in = 1'b0;
		repeat (2) @(negedge core_clk_in);
		resetn_in = 1'b1;
		cmp(24'({mode, mism, unsafe, fs_out}), 24'({ccrs_pkg::CCRS_MODE_HIGH_PERF, 2'b00, 16'hA000}));
		cal = 1'b1;
		acc(1'b1, 1'b0, 8'h37, 8'h4B, 8'h00);
		cal = 1'b0;
		cmp(24'(unsafe), 24'h000001);
		$display("test 4 done");
		acc(1'b1, 1'b0, 8'h3B, 8'h03, 8'h00);
		cmp(24'({ts_term, ts_rx}), 24'h000003);
		acc(1'b1, 1'b0, 8'h3C, 8'h00, 8'h00);
		cmp(24'(refo), 24'h000000);
		acc(1'b1, 1'b0, 8'h3C, 8'h01, 8'h00);
		cmp(24'(refo), 24'h000001);
		pll = 1'b0;
		acc(1'b1, 1'b1, 8'h3D, p[7:0], 8'h00);
		cmp(24'({refo, fb}), 24'({1'b0, p[7:0]}));
		$display("test 5 done");
		repeat (2) @(negedge core_clk_in);
		cmp(24'(exp_q.size()), 24'h000000);
		report_and_stop();
	end
endmodule
`default_nettype wire
